// ==== core/dmamb_defines.svh ====
// Overview of operation
// - reloaded-source list mode: restore source, block irq
// - after block sample row; rows 1,5 end
// - transfer done sets irq and disables channel
// - enabled unmasked block irq stalls a non-final block until clear
// - disabled or masked block irq never stalls
// - non-final list-mode block fetches descriptor from list pointer
// - handshake select 0 hardware, 1 software
// - hardware requests routed by peripheral index fields
// - channel starts when enable and global enable
// - device acknowledges each peripheral transaction
// - contiguous mode: reload source, keep destination
// - contiguous mode: only row one ends transfer
// - channel enable readable, hardware clears at end
// - clear registers wipe raw and masked status
// - channel enable register reports each channel state
`ifndef DMAMB_DEFINES_SVH
`define DMAMB_DEFINES_SVH
// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define DMAMB_OFS_SAR0 8'h00
`define DMAMB_OFS_DAR0 8'h04
`define DMAMB_OFS_LLP0 8'h08
`define DMAMB_OFS_CTL0 8'h0c
`define DMAMB_OFS_CFG0 8'h10
`define DMAMB_CH_STRIDE 8'h20
`define DMAMB_OFS_GCFG 8'h40
`define DMAMB_OFS_CHEN 8'h44
`define DMAMB_OFS_MASKBLK 8'h48
`define DMAMB_OFS_RAWTFR 8'h4c
`define DMAMB_OFS_RAWBLK 8'h50
`define DMAMB_OFS_STATTFR 8'h54
`define DMAMB_OFS_STATBLK 8'h58
`define DMAMB_OFS_CLRTFR 8'h5c
`define DMAMB_OFS_CLRBLK 8'h60
`define DMAMB_OFS_CLRSRC 8'h64
`define DMAMB_OFS_CLRDST 8'h68
`define DMAMB_OFS_CLRERR 8'h6c
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define DMAMB_CTL_INT_EN 0
`define DMAMB_CTL_LLP_DST 27
`define DMAMB_CTL_LLP_SRC 28
`define DMAMB_CFG_HS_DST 10
`define DMAMB_CFG_HS_SRC 11
`define DMAMB_CFG_RELOAD_SRC 30
`define DMAMB_CFG_RELOAD_DST 31
`define DMAMB_CFG_SRC_IDX_LO 4
`define DMAMB_CFG_DST_IDX_LO 8
`define DMAMB_GCFG_EN 0
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define DMAMB_RST_WORD 32'h0000_0000
`endif

// ==== core/dmamb_pkg.sv ====
package dmamb_pkg;
  // channel sequencer states, gray along idle-fetch-run-end-stall
  typedef enum logic [2:0] {
    DMAMB_IDLE = 3'b000,
    DMAMB_FETCH = 3'b001,
    DMAMB_RUN = 3'b011,
    DMAMB_BEND = 3'b010,
    DMAMB_STALL = 3'b110
  } dmamb_state_e;
  // mode rows of the multi-block table
  typedef enum logic [3:0] {
    DMAMB_ROW1 = 4'h1, DMAMB_ROW3 = 4'h3, DMAMB_ROW4 = 4'h4, DMAMB_ROW5 = 4'h5,
    DMAMB_ROW7 = 4'h7, DMAMB_ROW8 = 4'h8, DMAMB_ROWX = 4'hf
  } dmamb_row_e;
  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } dmamb_req_s;
  // memory read request for descriptor fetch
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
  } dmamb_mem_s;
endpackage

// ==== core/dmamb_chan.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dmamb_defines.svh"
// one channel sequencer: block loop, descriptor fetch, stall
module dmamb_chan
  import dmamb_pkg::*;
#(
  parameter int BLOCK_TXNS = 4
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic start, // enable with global enable
  input wire logic kill, // software clear of enable
  input wire logic [31:0] cfg,
  input wire logic [31:0] ctl,
  input wire logic [31:0] llp,
  input wire logic blk_unmasked,
  input wire logic blk_pending, // raw block flag
  input wire logic txn_ack, // one transaction finished
  input wire logic mem_rvalid,
  input wire logic [31:0] mem_rdata,
  output var dmamb_state_e state,
  output logic blk_done, // pulse at block end
  output logic tfr_done, // pulse at transfer end
  output logic reload_src, // restore source address
  output logic load_word, // descriptor word strobe
  output logic [1:0] word_idx,
  output dmamb_mem_s mem_req,
  output dmamb_row_e row
);
  // ------------------------------------------------------------
  // row decode
  // ------------------------------------------------------------
  // row from bits
  always_comb begin
    row = DMAMB_ROWX;
    case ({cfg[`DMAMB_CFG_RELOAD_SRC], cfg[`DMAMB_CFG_RELOAD_DST],
           ctl[`DMAMB_CTL_LLP_SRC], ctl[`DMAMB_CTL_LLP_DST], llp != 32'h0})
      5'b00000, 5'b00001: row = DMAMB_ROW1;
      5'b10000: row = DMAMB_ROW3;
      5'b11000: row = DMAMB_ROW4;
      5'b00011, 5'b00010: row = (llp == 32'h0) ? DMAMB_ROW5 : DMAMB_ROWX;
      5'b10011: row = DMAMB_ROW7;
      5'b00101: row = DMAMB_ROW8;
      default: row = DMAMB_ROWX;
    endcase
    // destination list mode with zero pointer and no source reload is last block
    if (!cfg[`DMAMB_CFG_RELOAD_SRC] && ctl[`DMAMB_CTL_LLP_DST] && llp == 32'h0) begin
      row = DMAMB_ROW5;
    end
  end
  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  dmamb_state_e state_r, state_nxt;
  logic [7:0] cnt_r, cnt_nxt; // transactions in block
  logic [1:0] widx_r, widx_nxt; // descriptor word
  logic [31:0] ptr_r, ptr_nxt; // fetch base
  logic list_mode; // any list pointer enable
  assign list_mode = ctl[`DMAMB_CTL_LLP_DST] | ctl[`DMAMB_CTL_LLP_SRC];
  // next-state logic
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    widx_nxt = widx_r;
    ptr_nxt = (state_r == DMAMB_FETCH) ? ptr_r : llp;
    blk_done = 1'b0;
    tfr_done = 1'b0;
    reload_src = 1'b0;
    load_word = 1'b0;
    mem_req = '0;
    case (state_r)
      DMAMB_IDLE: begin
        if (start) begin
          cnt_nxt = 8'h0;
          widx_nxt = 2'h0;
          state_nxt = (list_mode && llp != 32'h0) ? DMAMB_FETCH : DMAMB_RUN;
        end
      end
      DMAMB_FETCH: begin
        mem_req.valid = 1'b1;
        mem_req.addr = ptr_r + {28'h0, widx_r, 2'b00};
        if (mem_rvalid) begin
          load_word = 1'b1;
          widx_nxt = widx_r + 2'h1;
          if (widx_r == 2'h3) begin
            state_nxt = DMAMB_RUN;
          end
        end
      end
      DMAMB_RUN: begin
        if (txn_ack) begin
          cnt_nxt = cnt_r + 8'h1;
          if (cnt_r == 8'(BLOCK_TXNS - 1)) begin
            state_nxt = DMAMB_BEND;
          end
        end
      end
      DMAMB_BEND: begin
        blk_done = 1'b1;
        reload_src = cfg[`DMAMB_CFG_RELOAD_SRC];
        cnt_nxt = 8'h0;
        widx_nxt = 2'h0;
        if (row == DMAMB_ROW1 || (row == DMAMB_ROW5 && list_mode)) begin
          tfr_done = 1'b1;
          state_nxt = DMAMB_IDLE;
        end else if (ctl[`DMAMB_CTL_INT_EN] && blk_unmasked) begin
          state_nxt = DMAMB_STALL;
        end else begin
          state_nxt = list_mode ? DMAMB_FETCH : DMAMB_RUN;
        end
      end
      DMAMB_STALL: begin
        if (!blk_pending) begin
          state_nxt = list_mode ? DMAMB_FETCH : DMAMB_RUN;
        end
      end
      default: state_nxt = DMAMB_IDLE;
    endcase
    // software abort wins over everything
    if (kill) begin
      state_nxt = DMAMB_IDLE;
    end
  end
  // state registers
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state_r <= DMAMB_IDLE;
      cnt_r <= 8'h0;
      widx_r <= 2'h0;
      ptr_r <= 32'h0;
    end else if (ce) begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      widx_r <= widx_nxt;
      ptr_r <= ptr_nxt;
    end
  end
  assign state = state_r;
  assign word_idx = widx_r;
endmodule
`default_nettype wire

// ==== core/dmamb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dmamb_defines.svh"
// two-channel multi-block sequencer with register port
module dmamb_top
  import dmamb_pkg::*;
#(
  parameter int NCH = 2,
  parameter int BLOCK_TXNS = 4,
  parameter int NPER = 16
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire dmamb_req_s req,
  output logic [31:0] rdata,
  output dmamb_mem_s [NCH-1:0] mem_req,
  input wire logic [NCH-1:0] mem_rvalid,
  input wire logic [31:0] mem_rdata,
  input wire logic [NPER-1:0] hw_req, // peripheral requests
  input wire logic [NCH-1:0] sw_src_req, // software source requests
  input wire logic [NCH-1:0] sw_dst_req, // software destination requests
  input wire logic [NCH-1:0] txn_done, // transaction finished on bus
  output logic [NCH-1:0] src_req_sel, // routed source request
  output logic [NCH-1:0] dst_req_sel, // routed destination request
  output logic [NPER-1:0] hw_ack, // acknowledge per peripheral
  output logic [NCH-1:0] chan_busy,
  output logic [NCH-1:0][31:0] chan_source_address,
  output logic [NCH-1:0][31:0] chan_destination_address
);
  // ------------------------------------------------------------
  // channel registers
  // ------------------------------------------------------------
  logic [NCH-1:0][31:0] sar_r, sar_nxt, sar_init_r, sar_init_nxt;
  logic [NCH-1:0][31:0] dar_r, dar_nxt, llp_r, llp_nxt;
  logic [NCH-1:0][31:0] ctl_r, ctl_nxt, cfg_r, cfg_nxt;
  logic [NCH-1:0] chen_r, chen_nxt; // channel_on_bit per channel
  logic [NCH-1:0] mask_r, mask_nxt; // block_irq_mask
  logic [NCH-1:0] rtfr_r, rtfr_nxt, rblk_r, rblk_nxt; // raw flags
  logic [NCH-1:0] rsrc_r, rsrc_nxt, rdst_r, rdst_nxt, rerr_r, rerr_nxt;
  logic gen_r, gen_nxt; // global_configuration enable
  logic [31:0] rdata_r, rdata_nxt;
  // per-channel sequencer results
  logic [NCH-1:0] blk_done, tfr_done, reload_src, load_word;
  logic [NCH-1:0][1:0] widx;
  dmamb_state_e [NCH-1:0] st;
  logic [NCH-1:0] start, kill;
  // ------------------------------------------------------------
  // channel instances and handshake routing
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      logic [3:0] si, di;
      logic wr_en;
      assign wr_en = req.wr && req.addr == `DMAMB_OFS_CHEN;
      assign start[g] = chen_r[g] && gen_r;
      assign si = cfg_r[g][`DMAMB_CFG_SRC_IDX_LO +: 4];
      assign di = cfg_r[g][`DMAMB_CFG_DST_IDX_LO +: 4];
      assign src_req_sel[g] = cfg_r[g][`DMAMB_CFG_HS_SRC] ? sw_src_req[g] : hw_req[si];
      assign dst_req_sel[g] = cfg_r[g][`DMAMB_CFG_HS_DST] ? sw_dst_req[g] : hw_req[di];
      assign kill[g] = chen_r[g] && wr_en && !req.wdata[g] && req.wdata[g+8];
      assign chan_busy[g] = st[g] == DMAMB_RUN;
      dmamb_chan #(.BLOCK_TXNS(BLOCK_TXNS)) u_chan (
        .clk_sys(clk_sys), .rstn(rstn), .ce(ce),
        .start(start[g]), .kill(kill[g]),
        .cfg(cfg_r[g]), .ctl(ctl_r[g]), .llp(llp_r[g]),
        .blk_unmasked(mask_r[g]), .blk_pending(rblk_r[g]),
        .txn_ack(txn_done[g] && st[g] == DMAMB_RUN),
        .mem_rvalid(mem_rvalid[g]), .mem_rdata(mem_rdata),
        .state(st[g]), .blk_done(blk_done[g]), .tfr_done(tfr_done[g]),
        .reload_src(reload_src[g]), .load_word(load_word[g]),
        .word_idx(widx[g]), .mem_req(mem_req[g]), .row()
      );
    end
  endgenerate
  always_comb begin
    hw_ack = '0;
    for (int c = 0; c < NCH; c++) begin
      if (txn_done[c] && st[c] == DMAMB_RUN) begin
        if (!cfg_r[c][`DMAMB_CFG_HS_SRC]) begin
          hw_ack[cfg_r[c][`DMAMB_CFG_SRC_IDX_LO +: 4]] = 1'b1;
        end
        if (!cfg_r[c][`DMAMB_CFG_HS_DST]) begin
          hw_ack[cfg_r[c][`DMAMB_CFG_DST_IDX_LO +: 4]] = 1'b1;
        end
      end
    end
  end
  // ------------------------------------------------------------
  // register file next values
  // ------------------------------------------------------------
  always_comb begin
    logic [7:0] base;
    logic [7:0] ofs;
    base = 8'h0;
    ofs = 8'h0;
    sar_nxt = sar_r;
    sar_init_nxt = sar_init_r;
    dar_nxt = dar_r;
    llp_nxt = llp_r;
    ctl_nxt = ctl_r;
    cfg_nxt = cfg_r;
    chen_nxt = chen_r;
    mask_nxt = mask_r;
    rtfr_nxt = rtfr_r;
    rblk_nxt = rblk_r;
    rsrc_nxt = rsrc_r;
    rdst_nxt = rdst_r;
    rerr_nxt = rerr_r;
    gen_nxt = gen_r;
    rdata_nxt = 32'h0;
    for (int c = 0; c < NCH; c++) begin
      base = 8'(c) * `DMAMB_CH_STRIDE;
      ofs = req.addr - base;
      if (req.wr && req.addr >= base && req.addr < base + `DMAMB_CH_STRIDE) begin
        case (ofs)
          `DMAMB_OFS_SAR0: begin
            sar_nxt[c] = req.wdata;
            sar_init_nxt[c] = req.wdata;
          end
          `DMAMB_OFS_DAR0: dar_nxt[c] = req.wdata;
          `DMAMB_OFS_LLP0: llp_nxt[c] = req.wdata;
          `DMAMB_OFS_CTL0: ctl_nxt[c] = req.wdata;
          `DMAMB_OFS_CFG0: cfg_nxt[c] = req.wdata;
          default: ;
        endcase
      end
      if (req.rd && req.addr >= base && req.addr < base + `DMAMB_CH_STRIDE) begin
        case (ofs)
          `DMAMB_OFS_SAR0: rdata_nxt = sar_r[c];
          `DMAMB_OFS_DAR0: rdata_nxt = dar_r[c];
          `DMAMB_OFS_LLP0: rdata_nxt = llp_r[c];
          `DMAMB_OFS_CTL0: rdata_nxt = ctl_r[c];
          `DMAMB_OFS_CFG0: rdata_nxt = cfg_r[c];
          default: rdata_nxt = 32'h0;
        endcase
      end
      if (load_word[c]) begin
        case (widx[c])
          2'h0: if (ctl_r[c][`DMAMB_CTL_LLP_SRC]) sar_nxt[c] = mem_rdata;
          2'h1: if (ctl_r[c][`DMAMB_CTL_LLP_DST]) dar_nxt[c] = mem_rdata;
          2'h2: llp_nxt[c] = mem_rdata;
          default: ctl_nxt[c] = mem_rdata;
        endcase
      end
      if (reload_src[c]) begin
        sar_nxt[c] = sar_init_r[c];
      end
    end
    // global registers
    if (req.wr) begin
      case (req.addr)
        `DMAMB_OFS_GCFG: gen_nxt = req.wdata[`DMAMB_GCFG_EN];
        `DMAMB_OFS_MASKBLK: mask_nxt = req.wdata[NCH-1:0];
        // write-enable bits in the second byte (bit 8 up) gate each channel
        `DMAMB_OFS_CHEN: begin
          for (int c = 0; c < NCH; c++) begin
            if (req.wdata[c+8]) chen_nxt[c] = req.wdata[c];
          end
        end
        `DMAMB_OFS_CLRTFR: rtfr_nxt = rtfr_r & ~req.wdata[NCH-1:0];
        `DMAMB_OFS_CLRBLK: rblk_nxt = rblk_r & ~req.wdata[NCH-1:0];
        `DMAMB_OFS_CLRSRC: rsrc_nxt = rsrc_r & ~req.wdata[NCH-1:0];
        `DMAMB_OFS_CLRDST: rdst_nxt = rdst_r & ~req.wdata[NCH-1:0];
        `DMAMB_OFS_CLRERR: rerr_nxt = rerr_r & ~req.wdata[NCH-1:0];
        default: ;
      endcase
    end
    // hardware sets win over same-cycle clears
    rblk_nxt = rblk_nxt | blk_done;
    rtfr_nxt = rtfr_nxt | tfr_done;
    rsrc_nxt = rsrc_nxt | (txn_done & chan_busy);
    rdst_nxt = rdst_nxt | (txn_done & chan_busy);
    chen_nxt = chen_nxt & ~tfr_done;
    if (req.rd) begin
      case (req.addr)
        `DMAMB_OFS_GCFG: rdata_nxt = {31'h0, gen_r};
        `DMAMB_OFS_CHEN: rdata_nxt = {{(32-NCH){1'b0}}, chen_r};
        `DMAMB_OFS_MASKBLK: rdata_nxt = {{(32-NCH){1'b0}}, mask_r};
        `DMAMB_OFS_RAWTFR: rdata_nxt = {{(32-NCH){1'b0}}, rtfr_r};
        `DMAMB_OFS_RAWBLK: rdata_nxt = {{(32-NCH){1'b0}}, rblk_r};
        `DMAMB_OFS_STATTFR: rdata_nxt = {{(32-NCH){1'b0}}, rtfr_r};
        `DMAMB_OFS_STATBLK: rdata_nxt = {{(32-NCH){1'b0}}, rblk_r & mask_r};
        default: ;
      endcase
    end
  end
  // ------------------------------------------------------------
  // register file flops
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sar_r <= '0;
      sar_init_r <= '0;
      dar_r <= '0;
      llp_r <= '0;
      ctl_r <= '0;
      cfg_r <= '0;
      chen_r <= '0;
      mask_r <= '0;
      rtfr_r <= '0;
      rblk_r <= '0;
      rsrc_r <= '0;
      rdst_r <= '0;
      rerr_r <= '0;
      gen_r <= 1'b0;
      rdata_r <= `DMAMB_RST_WORD;
    end else if (ce) begin
      sar_r <= sar_nxt;
      sar_init_r <= sar_init_nxt;
      dar_r <= dar_nxt;
      llp_r <= llp_nxt;
      ctl_r <= ctl_nxt;
      cfg_r <= cfg_nxt;
      chen_r <= chen_nxt;
      mask_r <= mask_nxt;
      rtfr_r <= rtfr_nxt;
      rblk_r <= rblk_nxt;
      rsrc_r <= rsrc_nxt;
      rdst_r <= rdst_nxt;
      rerr_r <= rerr_nxt;
      gen_r <= gen_nxt;
      rdata_r <= rdata_nxt;
    end
  end
  assign rdata = rdata_r;
  assign chan_source_address = sar_r;
  assign chan_destination_address = dar_r;
endmodule
`default_nettype wire

// ==== dv/dmamb_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dmamb_defines.svh"
// watches channel 0 through shadow registers
module dmamb_monitor
  import dmamb_pkg::*;
#(
  parameter int NCH = 2,
  parameter int NPER = 16
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire dmamb_req_s req,
  input wire logic [31:0] rdata,
  input wire dmamb_mem_s [NCH-1:0] mem_req,
  input wire logic [NCH-1:0] mem_rvalid,
  input wire logic [31:0] mem_rdata,
  input wire logic [NPER-1:0] hw_req,
  input wire logic [NCH-1:0] sw_src_req,
  input wire logic [NCH-1:0] txn_done,
  input wire logic [NCH-1:0] src_req_sel,
  input wire logic [NPER-1:0] hw_ack,
  input wire logic [NCH-1:0] chan_busy,
  input wire logic [NCH-1:0][31:0] chan_source_address
);
  // ----
  // shadows
  // ----
  logic [31:0] sar_r, llp_r, cfg_r, base_r; // programmed and fetched words
  logic ctl_int_r, ctl_lst_r, mask_r, gen_r, vld_r; // single bits
  // written words override fetched ones in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      {sar_r, llp_r, cfg_r, base_r} <= '0;
      {ctl_int_r, ctl_lst_r, mask_r, gen_r, vld_r} <= '0;
    end else begin
      vld_r <= mem_req[0].valid;
      if (mem_req[0].valid && !vld_r) base_r <= mem_req[0].addr;
      if (mem_rvalid[0] && mem_req[0].addr == base_r + 32'h8) llp_r <= mem_rdata;
      if (mem_rvalid[0] && mem_req[0].addr == base_r + 32'hc) begin
        {ctl_lst_r, ctl_int_r} <= {mem_rdata[27], mem_rdata[0]};
      end
      if (req.wr) begin
        case (req.addr)
          `DMAMB_OFS_SAR0: sar_r <= req.wdata;
          `DMAMB_OFS_LLP0: llp_r <= req.wdata;
          `DMAMB_OFS_CTL0: {ctl_lst_r, ctl_int_r} <= {req.wdata[27], req.wdata[0]};
          `DMAMB_OFS_CFG0: cfg_r <= req.wdata;
          `DMAMB_OFS_GCFG: gen_r <= req.wdata[0];
          `DMAMB_OFS_MASKBLK: mask_r <= req.wdata[0];
          default: ;
        endcase
      end
    end
  end
  // ----
  // properties
  // ----
  a_start_needs_global: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(chan_busy[0]) |-> gen_r) else $error("channel ran without global enable");
  a_src_hw_route: assert property (@(posedge clk_sys) disable iff (!rstn)
    chan_busy[0] && !cfg_r[11] |-> src_req_sel[0] == hw_req[cfg_r[7:4]])
    else $error("hardware route wrong");
  a_src_sw_route: assert property (@(posedge clk_sys) disable iff (!rstn)
    chan_busy[0] && cfg_r[11] |-> src_req_sel[0] == sw_src_req[0])
    else $error("software route wrong");
  a_ack_with_done: assert property (@(posedge clk_sys) disable iff (!rstn)
    |hw_ack |-> |txn_done) else $error("ack without transaction");
  a_src_restored: assert property (@(posedge clk_sys) disable iff (!rstn)
    $fell(chan_busy[0]) |-> ##[0:1] chan_source_address[0] == sar_r)
    else $error("source not restored");
  a_stall_holds: assert property (@(posedge clk_sys) disable iff (!rstn)
    $fell(chan_busy[0]) && mask_r && ctl_int_r |-> !chan_busy[0] [*6])
    else $error("block end did not stall");
  a_nostall_runs: assert property (@(posedge clk_sys) disable iff (!rstn)
    $fell(chan_busy[0]) && !(mask_r && ctl_int_r) && cfg_r[30] && llp_r == 32'h0
    && !ctl_lst_r |-> ##[1:4] chan_busy[0]) else $error("block end did not resume");
  a_fetch_at_ptr: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(mem_req[0].valid) |-> mem_req[0].addr == llp_r) else $error("fetch not at pointer");
  a_fetch_walks: assert property (@(posedge clk_sys) disable iff (!rstn)
    mem_req[0].valid && $past(mem_req[0].valid) && $past(mem_rvalid[0])
    |-> mem_req[0].addr == $past(mem_req[0].addr) + 32'h4) else $error("fetch out of order");
  a_read_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
    !$past(req.rd) |-> rdata == 32'h0) else $error("read data outside its cycle");
endmodule
bind dmamb_top dmamb_monitor #(.NCH(NCH), .NPER(NPER)) dmamb_monitor_i (
  .clk_sys(clk_sys), .rstn(rstn), .req(req), .rdata(rdata), .mem_req(mem_req),
  .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .hw_req(hw_req), .sw_src_req(sw_src_req),
  .txn_done(txn_done), .src_req_sel(src_req_sel), .hw_ack(hw_ack), .chan_busy(chan_busy),
  .chan_source_address(chan_source_address)
);
`default_nettype wire

// ==== dv/dmamb_far.sv ====
`timescale 1ns/1ps
`default_nettype none
// descriptor memory and transacting peripherals
module dmamb_far
  import dmamb_pkg::*;
#(
  parameter int NCH = 2
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [3:0] slow, // extra idle cycles per answer
  input wire dmamb_mem_s [NCH-1:0] mem_req,
  input wire logic [NCH-1:0] chan_busy,
  output logic [NCH-1:0] mem_rvalid,
  output logic [31:0] mem_rdata,
  output logic [NCH-1:0] txn_done
);
  logic [3:0] wait_r; // answer spacing
  // chain of two, last has zero pointer
  function automatic logic [31:0] word_at(input logic [31:0] a);
    case (a)
      32'h104: return 32'h0000_2000;
      32'h108: return 32'h0000_0110;
      32'h10c, 32'h11c: return 32'h0800_0001;
      32'h114: return 32'h0000_3000;
      32'h118: return 32'h0000_0000;
      default: return ~a; // unused source word
    endcase
  endfunction
  // transactions finish only while a block runs
  always_ff @(posedge clk_sys) begin
    mem_rvalid <= '0;
    txn_done <= '0;
    mem_rdata <= ~mem_rdata; // data not valid keeps changing
    if (!rstn) begin
      wait_r <= '0;
      mem_rdata <= '0;
    end else if (wait_r != 4'h0) begin
      wait_r <= wait_r - 4'h1;
    end else begin
      wait_r <= slow + 4'h1;
      for (int c = 0; c < NCH; c++) begin
        if (mem_req[c].valid) begin
          mem_rvalid[c] <= 1'b1;
          mem_rdata <= word_at(mem_req[c].addr);
        end else if (chan_busy[c]) begin
          txn_done[c] <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== dv/dmamb_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dmamb_defines.svh"
module dmamb_top_tb
  import dmamb_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  dmamb_req_s req = '0;
  dmamb_mem_s [1:0] mem_req;
  logic [15:0] hw_req = '0;
  logic [15:0] hw_ack;
  logic [1:0] sw_src_req = '0, sw_dst_req = '0;
  logic [1:0] txn_done, src_req_sel, dst_req_sel, chan_busy, mem_rvalid;
  logic [3:0] slow = '0; // partner answer speed
  logic [31:0] rdata, mem_rdata;
  logic [1:0][31:0] sar_o, dar_o;
  int err_total = 0, checked = 0;
  always #2 clk_sys = ~clk_sys; // 250 MHz
  dmamb_top dmamb_top_i (.clk_sys(clk_sys),
    .rstn(rstn), .ce(1'b1), .req(req), .rdata(rdata), .mem_req(mem_req),
    .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .hw_req(hw_req),
    .sw_src_req(sw_src_req), .sw_dst_req(sw_dst_req), .txn_done(txn_done),
    .src_req_sel(src_req_sel), .dst_req_sel(dst_req_sel), .hw_ack(hw_ack),
    .chan_busy(chan_busy), .chan_source_address(sar_o), .chan_destination_address(dar_o));
  dmamb_far #(.NCH(2)) dmamb_far_i (.clk_sys(clk_sys), .rstn(rstn), .slow(slow),
    .mem_req(mem_req), .chan_busy(chan_busy), .mem_rvalid(mem_rvalid),
    .mem_rdata(mem_rdata), .txn_done(txn_done));
  // ----
  // shared tasks
  // ----
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, got);
    checked++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask
  // a hang ends the run at once
  task automatic stuck(input string nm);
    $display("mismatch %s expected done seen timeout", nm);
    err_total++;
    give_verdict();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    req <= '0;
  endtask
  // read data stands only in the next cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk_sys);
    req <= '0;
    #1 d = rdata;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, e, input string nm);
    logic [31:0] v;
    rd(a, v);
    chk(nm, e, v & m);
  endtask
  task automatic wait_busy(input int c, input logic v, input int lim);
    int n;
    for (n = 0; n < lim; n++) begin
      @(posedge clk_sys);
      #1;
      if (chan_busy[c] === v) break;
    end
    checked++;
    if (n == lim) stuck("chan_busy");
  endtask
  task automatic poll_off(input int c);
    logic [31:0] v;
    int n;
    for (n = 0; n < 60; n++) begin
      rd(`DMAMB_OFS_CHEN, v);
      if (v[c] === 1'b0) break;
    end
    checked++;
    if (n == 60) stuck("channel_on_bit");
  endtask
  task automatic prog(input int c, input logic [31:0] s, d, l, t, f);
    logic [7:0] b;
    b = (c == 1) ? `DMAMB_CH_STRIDE : 8'h00;
    wr(b + `DMAMB_OFS_SAR0, s);
    wr(b + `DMAMB_OFS_DAR0, d);
    wr(b + `DMAMB_OFS_LLP0, l);
    wr(b + `DMAMB_OFS_CTL0, t);
    wr(b + `DMAMB_OFS_CFG0, f);
  endtask
  // ----
  // scenarios
  // ----
  task automatic s_idle();
    rdchk(`DMAMB_OFS_CHEN, 32'hffff_ffff, 32'h0, "channel_enable_register");
    wr(8'h7c, 32'hffff_ffff);
    rdchk(8'h7c, 32'hffff_ffff, 32'h0, "unmapped");
  endtask
  // contiguous mode, masked block end runs on
  task automatic s_row3_free();
    prog(0, 32'h1000, 32'h4000, 32'h0, 32'h1, 32'h4000_0430);
    wr(`DMAMB_OFS_CHEN, 32'h101);
    repeat (8) @(posedge clk_sys);
    #1 chk("busy_no_global", 32'h0, chan_busy[0]);
    wr(`DMAMB_OFS_GCFG, 32'h1);
    wr(`DMAMB_OFS_CHEN, 32'h101);
    wait_busy(0, 1'b1, 20);
    @(posedge clk_sys);
    hw_req <= 16'h0008;
    sw_src_req <= 2'b01;
    sw_dst_req <= 2'b01;
    #1 chk("src_req_sel", 32'h1, src_req_sel[0]);
    chk("dst_req_sel", 32'h1, dst_req_sel[0]);
    @(posedge clk_sys);
    hw_req <= '0;
    #1 chk("src_req_sel", 32'h0, src_req_sel[0]);
    @(posedge clk_sys);
    sw_src_req <= '0;
    sw_dst_req <= '0;
    wait_busy(0, 1'b0, 100);
    wait_busy(0, 1'b1, 4);
    wait_busy(0, 1'b0, 100);
    wr(`DMAMB_OFS_CFG0, 32'h0000_0430);
    wait_busy(0, 1'b1, 4);
    wait_busy(0, 1'b0, 100);
    poll_off(0);
    chk("source_address", 32'h1000, sar_o[0]);
    chk("destination_address", 32'h4000, dar_o[0]);
    rdchk(`DMAMB_OFS_RAWTFR, 32'h1, 32'h1, "raw_transfer");
    rdchk(`DMAMB_OFS_RAWBLK, 32'h1, 32'h1, "raw_block");
  endtask
  // contiguous mode on channel 1, stalls at block end
  task automatic s_row3_stall();
    @(posedge clk_sys);
    slow <= 4'h3;
    wr(`DMAMB_OFS_MASKBLK, 32'h2);
    prog(1, 32'h1100, 32'h4100, 32'h0, 32'h1, 32'h4000_0c00);
    wr(`DMAMB_OFS_CHEN, 32'h202);
    wait_busy(1, 1'b1, 20);
    wait_busy(1, 1'b0, 200);
    repeat (10) @(posedge clk_sys);
    #1 chk("busy_stalled", 32'h0, chan_busy[1]);
    rdchk(`DMAMB_OFS_RAWBLK, 32'h2, 32'h2, "raw_block");
    rdchk(`DMAMB_OFS_CHEN, 32'h2, 32'h2, "channel_on_bit");
    wr(`DMAMB_CH_STRIDE + `DMAMB_OFS_CFG0, 32'h0000_0c00);
    wr(`DMAMB_OFS_CLRBLK, 32'h2);
    wait_busy(1, 1'b1, 8);
    wait_busy(1, 1'b0, 200);
    poll_off(1);
    chk("source_address", 32'h1100, sar_o[1]);
    chk("destination_address", 32'h4100, dar_o[1]);
  endtask
  task automatic s_clear();
    rdchk(`DMAMB_OFS_RAWTFR, 32'h3, 32'h3, "raw_transfer");
    for (int i = 0; i < 5; i++) wr(`DMAMB_OFS_CLRTFR + 8'(4 * i), 32'h3);
    for (int i = 0; i < 4; i++) rdchk(`DMAMB_OFS_RAWTFR + 8'(4 * i), 32'h3, 32'h0, "status");
  endtask
  // reloaded source, listed destination, stalls
  task automatic s_row7();
    @(posedge clk_sys);
    slow <= 4'h1;
    wr(`DMAMB_OFS_MASKBLK, 32'h1);
    prog(0, 32'h1800, 32'h5000, 32'h100, 32'h0800_0001, 32'h4000_0c00);
    wr(`DMAMB_OFS_CHEN, 32'h101);
    wait_busy(0, 1'b1, 100);
    chk("destination_address", 32'h2000, dar_o[0]);
    wait_busy(0, 1'b0, 100);
    repeat (8) @(posedge clk_sys);
    #1 chk("source_address", 32'h1800, sar_o[0]);
    rdchk(`DMAMB_OFS_RAWBLK, 32'h1, 32'h1, "raw_block");
    wr(`DMAMB_OFS_CFG0, 32'h0000_0c00);
    wr(`DMAMB_OFS_CLRBLK, 32'h1);
    wait_busy(0, 1'b1, 100);
    chk("destination_address", 32'h3000, dar_o[0]);
    chk("source_address", 32'h1800, sar_o[0]);
    wait_busy(0, 1'b0, 100);
    poll_off(0);
    rdchk(`DMAMB_OFS_RAWTFR, 32'h1, 32'h1, "raw_transfer");
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    s_idle();
    s_row3_free();
    s_row3_stall();
    s_clear();
    s_row7();
    give_verdict();
  end
endmodule
`default_nettype wire
